/* File: include/pclpb_pkg.sv */
// Package for the ACS, LTR and power budget configuration register bank
package pclpb_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_PWR_BUDGET_CAP  = 12'h218;
    localparam logic [11:0] OFS_ACS_HEADER      = 12'h220;
    localparam logic [11:0] OFS_ACS_CAP_EN      = 12'h224;
    localparam logic [11:0] OFS_EGRESS_VEC      = 12'h228;
    localparam logic [11:0] OFS_LTR_HEADER      = 12'h230;
    localparam logic [11:0] OFS_MAX_LATENCY     = 12'h234;
    // Preceding power budget header, holds the chain pointer
    localparam logic [11:0] OFS_PWR_BUDGET_HDR  = 12'h20c;

    // ==========================================================
    // Extended capability header contents
    localparam logic [15:0] PWR_BUDGET_CAP_ID   = 16'h0004;
    localparam logic [15:0] ACS_CAP_ID          = 16'h000d;
    localparam logic [15:0] LTR_CAP_ID          = 16'h0018;
    localparam logic [3:0]  CAP_VERSION         = 4'h1;
    localparam logic [11:0] NEXT_PTR_END        = 12'h000;
    localparam logic [11:0] NEXT_PTR_UPSTREAM   = 12'h230;
    localparam logic [11:0] NEXT_PTR_DOWNSTREAM = 12'h220;

    // ==========================================================
    // Field layouts and reset values
    localparam int          ACS_FEATURES        = 7;
    localparam logic [6:0]  ACS_CAP_BITS        = 7'h7f;
    localparam logic [7:0]  EGRESS_VEC_SIZE     = 8'h08;
    localparam int          ACS_SIZE_LSB        = 8;
    localparam int          ACS_EN_LSB          = 16;
    localparam logic [6:0]  ACS_EN_RESET        = 7'h00;
    localparam logic [7:0]  EGRESS_VEC_RESET    = 8'h00;
    localparam logic        SYS_ALLOC_RESET     = 1'b0;
    localparam logic [9:0]  LAT_VALUE_RESET     = 10'h000;
    localparam logic [2:0]  LAT_SCALE_RESET     = 3'h0;
    localparam int          SNOOP_LSB           = 0;
    localparam int          NOSNOOP_LSB         = 16;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [2:0] scale;   // Latency scale
        logic [9:0] value;   // Latency value
    } pclpb_latency_t;

    typedef struct packed {
        logic [11:0] addr;   // Byte address
        logic [31:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } pclpb_req_t;

endpackage

/* File: rtl/pclpb_acs_enables.sv */
// Seven ACS feature enables, one flop per bit
`timescale 1ns/1ps
module pclpb_acs_enables (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Write side
    input  wire logic                     wr_en,
    input  wire logic [6:0]               wr_bits,
    // Enable levels
    output logic [6:0]                    en
);

    // ==========================================================
    // One flop per feature, kept apart so routing logic taps each bit
    genvar i;
    generate
        for (i = 0; i < pclpb_pkg::ACS_FEATURES; i++) begin : g_en
            logic en_q;  // Feature enable
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    en_q <= pclpb_pkg::ACS_EN_RESET[i];
                end else if (wr_en) begin
                    en_q <= wr_bits[i];
                end
            end
            assign en[i] = en_q;
        end
    endgenerate

endmodule

/* File: rtl/pclpb_latency_field.sv */
// One LTR maximum latency field: value plus scale, reserved top bits
`timescale 1ns/1ps
module pclpb_latency_field (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Write side
    input  wire logic                     wr_en,
    input  wire logic [15:0]              wr_half,
    // Stored field
    output pclpb_pkg::pclpb_latency_t     lat
);

    pclpb_pkg::pclpb_latency_t lat_q;  // Stored value and scale

    // ==========================================================
    // Storage; bits 15:13 are reserved and simply not kept
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lat_q.value <= pclpb_pkg::LAT_VALUE_RESET;
            lat_q.scale <= pclpb_pkg::LAT_SCALE_RESET;
        end else if (wr_en) begin
            lat_q <= wr_half[12:0];
        end
    end

    assign lat = lat_q;

endmodule

/* File: rtl/pclpb_regs.sv */
// Configuration register bank: power budget flag, ACS and LTR capabilities
// Notes on behaviour
// - Read-only system-allocated flag, bit 0, resets zero
// - Downstream ACS header: ID 000Dh, version 1
// - Access_control_cap_and_enable bits 0-6 read as ones
// - Egress vector size field reads 08h
// - Seven read-write ACS enables, bits 16-22, reset zero
// - Downstream egress vector bits 7:0, read-write, reset zero
// - Upstream LTR header: ID 0018h, version 1
// - Snoop latency value and scale, read-write, reset zero
// - No-snoop latency value and scale in upper half
// - Power budget next pointer: 230h up, 220h down
`timescale 1ns/1ps
module pclpb_regs (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // Port role
    input  wire logic                     is_upstream,
    // Autoload default of the system-allocated flag
    input  wire logic                     sys_alloc_load,
    input  wire logic                     sys_alloc_load_val,
    // Register port
    input  wire logic [11:0]              reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    // Control levels toward packet routing
    output logic [6:0]                    acs_enable,
    output logic [7:0]                    egress_block,
    output pclpb_pkg::pclpb_latency_t     snoop_lat,
    output pclpb_pkg::pclpb_latency_t     nosnoop_lat,
    output logic                          sys_alloc
);

    // ==========================================================
    // Request bundle and decode
    pclpb_pkg::pclpb_req_t req;  // Bundled request
    logic        hit_acs;        // ACS capability present, set on the downstream role alone
    logic        hit_ltr;        // LTR capability present, set on the upstream role alone
    logic        wr_acs_cap;     // Write to Access_control_cap_and_enable word
    logic        wr_egress;      // Write to egress vector
    logic        wr_latency;     // Write to latency word
    logic        sys_alloc_q;    // System-allocated flag
    logic [7:0]  egress_q;       // Egress control vector
    logic [31:0] rdata_d;        // Read mux result
    logic [31:0] rdata_q;        // Registered read data

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Capabilities only exist on their own port role
    assign hit_acs    = !is_upstream;
    assign hit_ltr    = is_upstream;
    assign wr_acs_cap = req.wr && hit_acs && (req.addr == pclpb_pkg::OFS_ACS_CAP_EN);
    assign wr_egress  = req.wr && hit_acs && (req.addr == pclpb_pkg::OFS_EGRESS_VEC);
    assign wr_latency = req.wr && hit_ltr && (req.addr == pclpb_pkg::OFS_MAX_LATENCY);

    // ==========================================================
    // System-allocated flag: no config write path, only autoload
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sys_alloc_q <= pclpb_pkg::SYS_ALLOC_RESET;
        end else if (sys_alloc_load) begin
            sys_alloc_q <= sys_alloc_load_val;
        end
    end

    // ==========================================================
    // Egress control vector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            egress_q <= pclpb_pkg::EGRESS_VEC_RESET;
        end else if (wr_egress) begin
            egress_q <= req.wdata[7:0];
        end
    end

    // ==========================================================
    // ACS enables, only bits 22:16 are writable
    pclpb_acs_enables u_acs_en (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (wr_acs_cap),
        .wr_bits (req.wdata[pclpb_pkg::ACS_EN_LSB +: 7]),
        .en      (acs_enable)
    );

    // ==========================================================
    // LTR latency halves share one word and one write
    pclpb_latency_field u_snoop (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (wr_latency),
        .wr_half (req.wdata[pclpb_pkg::SNOOP_LSB +: 16]),
        .lat     (snoop_lat)
    );

    pclpb_latency_field u_nosnoop (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (wr_latency),
        .wr_half (req.wdata[pclpb_pkg::NOSNOOP_LSB +: 16]),
        .lat     (nosnoop_lat)
    );

    // ==========================================================
    // Read mux; constant fields come from the package, reserved read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (req.addr)
            pclpb_pkg::OFS_PWR_BUDGET_HDR: begin
                // Chain pointer picks the capability present on this role
                rdata_d = {(is_upstream ? pclpb_pkg::NEXT_PTR_UPSTREAM
                                        : pclpb_pkg::NEXT_PTR_DOWNSTREAM),
                           pclpb_pkg::CAP_VERSION, pclpb_pkg::PWR_BUDGET_CAP_ID};
            end
            pclpb_pkg::OFS_PWR_BUDGET_CAP: begin
                rdata_d = {31'h0000_0000, sys_alloc_q};
            end
            pclpb_pkg::OFS_ACS_HEADER: begin
                if (hit_acs) begin
                    rdata_d = {pclpb_pkg::NEXT_PTR_END, pclpb_pkg::CAP_VERSION,
                               pclpb_pkg::ACS_CAP_ID};
                end
            end
            pclpb_pkg::OFS_ACS_CAP_EN: begin
                if (hit_acs) begin
                    rdata_d = {9'h000, acs_enable, pclpb_pkg::EGRESS_VEC_SIZE,
                               1'b0, pclpb_pkg::ACS_CAP_BITS};
                end
            end
            pclpb_pkg::OFS_EGRESS_VEC: begin
                if (hit_acs) begin
                    rdata_d = {24'h00_0000, egress_q};
                end
            end
            pclpb_pkg::OFS_LTR_HEADER: begin
                if (hit_ltr) begin
                    rdata_d = {pclpb_pkg::NEXT_PTR_END, pclpb_pkg::CAP_VERSION,
                               pclpb_pkg::LTR_CAP_ID};
                end
            end
            pclpb_pkg::OFS_MAX_LATENCY: begin
                if (hit_ltr) begin
                    rdata_d = {3'h0, nosnoop_lat, 3'h0, snoop_lat};
                end
            end
            default: begin
                rdata_d = 32'h0000_0000;  // Unmapped reads zero
            end
        endcase
    end

    // ==========================================================
    // Read data stands one cycle after the strobe and only then
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata    = rdata_q;
    assign egress_block = egress_q;
    assign sys_alloc    = sys_alloc_q;

    // ==========================================================
    // Checks
    chk_sys_alloc_ro: assert property (@(posedge clk) disable iff (!rst_b)
        (!sys_alloc_load) |=> $stable(sys_alloc_q))
        else $error("system-allocated flag changed without autoload");

    chk_acs_header: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && reg_addr == 12'h220) |=> (reg_rdata == 32'h0001_000d))
        else $error("ACS header read wrong");

    chk_acs_cap_bits: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && reg_addr == 12'h224) |=> (reg_rdata[7:0] == 8'h7f))
        else $error("Access_control_cap_and_enable bits wrong");

    chk_vec_size: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && reg_addr == 12'h224) |=> (reg_rdata[15:8] == 8'h08))
        else $error("egress vector size wrong");

    chk_acs_enable_wr: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_wr && !is_upstream && reg_addr == 12'h224)
            |=> (acs_enable == $past(reg_wdata[22:16])))
        else $error("ACS enables not written");

    chk_egress_wr: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_wr && !is_upstream && reg_addr == 12'h228)
            |=> (egress_block == $past(reg_wdata[7:0])))
        else $error("egress vector not written");

    chk_ltr_header: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && is_upstream && reg_addr == 12'h230) |=> (reg_rdata == 32'h0001_0018))
        else $error("LTR header read wrong");

    chk_latency_wr: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_wr && is_upstream && reg_addr == 12'h234)
            |=> ({nosnoop_lat, snoop_lat} == {$past(reg_wdata[28:16]), $past(reg_wdata[12:0])}))
        else $error("latency word not written");

    chk_latency_rsvd: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == 12'h234) |=> (reg_rdata[31:29] == 3'h0 && reg_rdata[15:13] == 3'h0))
        else $error("latency reserved bits not zero");

    chk_chain_ptr: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == 12'h20c)
            |=> (reg_rdata[31:20] == ($past(is_upstream) ? 12'h230 : 12'h220)))
        else $error("power budget next pointer wrong");

    chk_upstream_no_acs: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_wr && is_upstream) |=> $stable(egress_block) && $stable(acs_enable))
        else $error("ACS state changed on upstream port");

    // ==========================================================
    // Read words against the stored state, and state held between writes
    // Autoload value lands in the flag one cycle after the pulse
    chk_alloc_load: assert property (@(posedge clk) disable iff (!rst_b)
        sys_alloc_load |=> (sys_alloc == $past(sys_alloc_load_val)))
        else $error("autoload value not taken by flag");

    // Flag in bit 0, all else reserved
    chk_alloc_read: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == pclpb_pkg::OFS_PWR_BUDGET_CAP)
            |=> (reg_rdata == {31'h0000_0000, $past(sys_alloc)}))
        else $error("power budget word read wrong");

    // Identifier and version of the preceding header never move
    chk_chain_low: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && reg_addr == pclpb_pkg::OFS_PWR_BUDGET_HDR)
            |=> (reg_rdata[19:0] == 20'h1_0004))
        else $error("power budget header low bits wrong");

    // Enables read back, reserved bits 31:23 and 7 stay zero
    chk_acs_en_read: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && reg_addr == pclpb_pkg::OFS_ACS_CAP_EN)
            |=> (reg_rdata[31:16] == {9'h000, $past(acs_enable)} && !reg_rdata[7]))
        else $error("ACS enable bits read wrong");

    // Enables only move on a write to their own word
    chk_acs_en_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && !is_upstream && reg_addr == pclpb_pkg::OFS_ACS_CAP_EN)
            |=> $stable(acs_enable))
        else $error("ACS enables changed without a write");

    // Vector reads back with the upper bits zero
    chk_egress_read: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && reg_addr == pclpb_pkg::OFS_EGRESS_VEC)
            |=> (reg_rdata == {24'h00_0000, $past(egress_block)}))
        else $error("egress vector read wrong");

    // Vector only moves on a write to its own word
    chk_egress_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && !is_upstream && reg_addr == pclpb_pkg::OFS_EGRESS_VEC)
            |=> $stable(egress_block))
        else $error("egress vector changed without a write");

    // Both latency halves read back in their own lanes
    chk_latency_read: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && is_upstream && reg_addr == pclpb_pkg::OFS_MAX_LATENCY)
            |=> (reg_rdata == {3'h0, $past(nosnoop_lat), 3'h0, $past(snoop_lat)}))
        else $error("latency word read wrong");

    // Latency halves only move on a write to their word
    chk_latency_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(reg_wr && is_upstream && reg_addr == pclpb_pkg::OFS_MAX_LATENCY)
            |=> ($stable(snoop_lat) && $stable(nosnoop_lat)))
        else $error("latency word changed without a write");

    // ACS words vanish on the upstream role
    chk_acs_absent: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && is_upstream && (reg_addr == pclpb_pkg::OFS_ACS_HEADER
            || reg_addr == pclpb_pkg::OFS_ACS_CAP_EN || reg_addr == pclpb_pkg::OFS_EGRESS_VEC))
            |=> (reg_rdata == 32'h0000_0000))
        else $error("ACS word visible on upstream port");

    // LTR words vanish on the downstream role
    chk_ltr_absent: assert property (@(posedge clk) disable iff (!rst_b)
        (reg_rd && !is_upstream && (reg_addr == pclpb_pkg::OFS_LTR_HEADER
            || reg_addr == pclpb_pkg::OFS_MAX_LATENCY))
            |=> (reg_rdata == 32'h0000_0000))
        else $error("LTR word visible on downstream port");

endmodule

/* File: tb/pclpb_regs_tb.sv */
// Self-checking testbench for the ACS, LTR and power budget register bank
`timescale 1ns/1ps
module pclpb_regs_tb;

    // ==========================================================
    // Stimulus and observation signals
    logic                          clk;                 // 50 MHz core clock
    logic                          rst_b;               // Async reset, active low
    logic                          is_upstream;         // Port role
    logic                          sys_alloc_load;      // Autoload pulse
    logic                          sys_alloc_load_val;  // Autoload value
    logic [11:0]                   reg_addr;            // Register address
    logic [31:0]                   reg_wdata;           // Register write data
    logic                          reg_wr;              // Write strobe
    logic                          reg_rd;              // Read strobe
    logic [31:0]                   reg_rdata;           // Read data, one cycle late
    logic [6:0]                    acs_enable;          // Feature enables
    logic [7:0]                    egress_block;        // Egress vector
    pclpb_pkg::pclpb_latency_t     snoop_lat;           // Snoop latency field
    pclpb_pkg::pclpb_latency_t     nosnoop_lat;         // No-snoop latency field
    logic                          sys_alloc;           // System-allocated flag
    logic [31:0]                   exp_q[$];            // Expected read data, oldest first
    logic                          rd_seen;             // A read was taken at the last edge
    logic [15:0]                   lfsr_q;              // Random source state
    logic [31:0]                   rnd;                 // Current random word
    int                            err_total;           // Mismatches
    int                            samples_checked;     // Comparisons made
    int                            cyc;                 // Cycles since start

    // ==========================================================
    // Device under test
    pclpb_regs u_pclpb_regs (
        .clk                (clk),
        .rst_b              (rst_b),
        .is_upstream        (is_upstream),
        .sys_alloc_load     (sys_alloc_load),
        .sys_alloc_load_val (sys_alloc_load_val),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .acs_enable         (acs_enable),
        .egress_block       (egress_block),
        .snoop_lat          (snoop_lat),
        .nosnoop_lat        (nosnoop_lat),
        .sys_alloc          (sys_alloc)
    );

    // ==========================================================
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // Shared helpers
    // Compare one value, count it, report a difference
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask

    // Fibonacci LFSR step, taps 16 14 13 11
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Two LFSR steps give one 32-bit word
    task automatic next_rnd();
        lfsr_q = lfsr_next(lfsr_q);
        rnd[31:16] = lfsr_q;
        lfsr_q = lfsr_next(lfsr_q);
        rnd[15:0] = lfsr_q;
    endtask

    // One-cycle write; strobes stay up if the next task follows at once
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clk);
    endtask

    // One-cycle read; the expected word goes to the monitor queue
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge clk);
    endtask

    // Drop both strobes for one cycle
    task automatic idle();
        reg_wr         <= 1'b0;
        reg_rd         <= 1'b0;
        sys_alloc_load <= 1'b0;
        @(posedge clk);
    endtask

    // Reset held 20 cycles; role only changes while in reset
    task automatic do_reset(input logic up);
        rst_b       <= 1'b0;
        is_upstream <= up;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask

    // Closing report, reached from the main flow or the timeout
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Read monitor: data stands only in the cycle after the read edge
    always @(posedge clk) begin
        rd_seen <= reg_rd & rst_b;
    end

    always @(negedge clk) begin
        if (rd_seen) begin
            check(reg_rdata, exp_q.pop_front());
        end else begin
            check(reg_rdata, 32'h0000_0000);
        end
    end

    // Hang guard: whole run needs well under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_b = 1'b0; is_upstream = 1'b0; sys_alloc_load = 1'b0; sys_alloc_load_val = 1'b0;
        reg_addr = 12'h000; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
        rd_seen = 1'b0; lfsr_q = 16'h8597; rnd = 32'h0;
        err_total = 0; samples_checked = 0; cyc = 0;
        @(posedge clk);
        do_reset(1'b0);
        // Downstream reset image, back-to-back reads
        rd(12'h218, 32'h0000_0000);
        rd(12'h20c, 32'h2201_0004);
        rd(12'h220, 32'h0001_000d);
        rd(12'h224, 32'h0000_087f);
        rd(12'h228, 32'h0000_0000);
        rd(12'h230, 32'h0000_0000);
        rd(12'h234, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        // Writes to read-only words and absent capability are dropped
        wr(12'h218, 32'hffff_ffff);
        wr(12'h220, 32'hffff_ffff);
        wr(12'h20c, 32'hffff_ffff);
        wr(12'h234, 32'hffff_ffff);
        rd(12'h218, 32'h0000_0000);
        rd(12'h220, 32'h0001_000d);
        rd(12'h20c, 32'h2201_0004);
        rd(12'h234, 32'h0000_0000);
        // All-ones: reserved and read-only bits of the mixed word hold
        wr(12'h224, 32'hffff_ffff);
        wr(12'h228, 32'hffff_ffff);
        rd(12'h224, 32'h007f_087f);
        rd(12'h228, 32'h0000_00ff);
        idle();
        @(negedge clk);
        check({25'h0, acs_enable}, 32'h0000_007f);
        check({24'h0, egress_block}, 32'h0000_00ff);
        check({19'h0, snoop_lat}, 32'h0000_0000);
        @(posedge clk);
        // Random enables and egress vectors
        repeat (6) begin
            next_rnd();
            wr(12'h224, rnd);
            rd(12'h224, {9'h0, rnd[22:16], 16'h087f});
            wr(12'h228, rnd);
            rd(12'h228, {24'h0, rnd[7:0]});
            idle();
            @(negedge clk);
            check({25'h0, acs_enable}, {25'h0, rnd[22:16]});
            check({24'h0, egress_block}, {24'h0, rnd[7:0]});
            @(posedge clk);
        end
        // Autoload sets then clears the flag
        sys_alloc_load <= 1'b1; sys_alloc_load_val <= 1'b1;
        @(posedge clk);
        sys_alloc_load <= 1'b0;
        wr(12'h218, 32'h0000_0000);
        rd(12'h218, 32'h0000_0001);
        idle();
        @(negedge clk);
        check({31'h0, sys_alloc}, 32'h0000_0001);
        @(posedge clk);
        sys_alloc_load <= 1'b1; sys_alloc_load_val <= 1'b0;
        @(posedge clk);
        sys_alloc_load <= 1'b0;
        rd(12'h218, 32'h0000_0000);
        // Drop the read strobe so no request is live across the reset
        idle();
        // Second reset in mid-run, now as upstream port
        do_reset(1'b1);
        @(negedge clk);
        check({25'h0, acs_enable}, 32'h0000_0000);
        check({24'h0, egress_block}, 32'h0000_0000);
        @(posedge clk);
        rd(12'h20c, 32'h2301_0004);
        rd(12'h230, 32'h0001_0018);
        rd(12'h234, 32'h0000_0000);
        rd(12'h220, 32'h0000_0000);
        wr(12'h224, 32'hffff_ffff);
        wr(12'h228, 32'hffff_ffff);
        wr(12'h230, 32'hffff_ffff);
        rd(12'h224, 32'h0000_0000);
        rd(12'h228, 32'h0000_0000);
        rd(12'h230, 32'h0001_0018);
        // Random latency words, reserved bits dropped
        repeat (6) begin
            next_rnd();
            wr(12'h234, rnd);
            rd(12'h234, rnd & 32'h1fff_1fff);
            idle();
            @(negedge clk);
            check({19'h0, snoop_lat}, {19'h0, rnd[12:0]});
            check({19'h0, nosnoop_lat}, {19'h0, rnd[28:16]});
            check({25'h0, acs_enable}, 32'h0000_0000);
            check({24'h0, egress_block}, 32'h0000_0000);
            @(posedge clk);
        end
        idle();
        repeat (3) @(posedge clk);
        give_verdict();
    end

endmodule
